// ==== core/sof_regs.sv ====
// Purpose: apb register bank for the serial output format settings
// Assumes: apb master with 32-bit data, pins asynchronous to pclk
// Notes:   zero wait states, read data captured in the setup cycle
//          status word is a read-only view of the effective settings
//          effective outputs lag the register by one edge, the pins by five
//
// Function
// RULE_01: bits 0-2 pick lanes, bit clock, serialization
// RULE_02: bit 4 capture edge, only with sdr
// RULE_03: bit 5 coarse gain 3.5 dB, 1.34 Vpp
// RULE_04: bit 6 selects msb or lsb first
// RULE_05: bit 7 byte or bit split, two-wire only
// RULE_06: pins govern fields while override is clear
// RULE_07: bit 10 set makes register override pins
// RULE_08: host writes zero to bits 9, 8, 3
//
// Added by the designer: the APB register port.
`include "sof_cfg.svh"
module sof_regs
  import sof_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // parallel configuration pins, asynchronous
  input  wire logic [6:0]  pin_fmt,
  // effective output format
  output logic             fmt_two_wire,
  output logic             fmt_sdr_clk,
  output logic             fmt_ser14,
  output logic             fmt_cap_rise,
  output logic             fmt_coarse_gain,
  output logic             fmt_lsb_first,
  output logic             fmt_bit_wise,
  // analog gain settings
  output logic [5:0]       gain_ddb,
  output logic [10:0]      fsr_mv
);

  // address decode
  // word index from paddr[11:2], low address bits ignored
  logic [9:0]  word_idx;    // word index of the access
  logic        hit_fmt;     // format register selected
  logic        hit_stat;    // status register selected
  logic        hit_any;     // any mapped register
  logic        acc_phase;   // apb access phase
  logic        setup_rd;    // setup cycle of a read
  logic        wr_fmt;      // write commit to the format register

  assign word_idx  = paddr[11:2];
  assign hit_fmt   = (word_idx == `SOF_FMT_IDX);
  assign hit_stat  = (word_idx == `SOF_STAT_IDX);
  assign hit_any   = hit_fmt | hit_stat;
  assign acc_phase = psel & penable;
  assign setup_rd  = psel & ~penable & ~pwrite;
  assign wr_fmt    = acc_phase & pwrite & hit_fmt;

  // every register answers at once, so no wait state is needed
  // slave never stalls
  assign pready  = 1'b1;
  // unmapped address answers with an error in the access phase
  assign pslverr = acc_phase & ~hit_any;

  // format register
  // stores what software wrote, dependent gating happens downstream
  sof_fmt_t fmt_q;   // stored format register
  sof_fmt_t fmt_d;   // next value

  // a write lands at the access edge, never in setup
  // reserved bits dropped so they always read as zero
  assign fmt_d = wr_fmt ? (pwdata[10:0] & `SOF_FMT_WMASK) : fmt_q; // RULE_08

  // format register storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_q <= `SOF_FMT_RST;
    end else begin
      fmt_q <= fmt_d; // RULE_07
    end
  end

  // pin synchronisation
  // pins move at any time, so they never feed logic unfiltered
  sof_fields_t pin_stable;   // filtered pin levels

  // pins are asynchronous, filter them before use
  sof_sync #(
    .W (`SOF_PIN_W)
  ) u_pin_sync (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin_async  (pin_fmt),
    .pin_stable (pin_stable)
  );

  // source selection
  // one resolver serves both sources, hence the shared pin order
  sof_fields_t reg_fields;   // register fields in pin order
  logic        ovrd;         // override bit

  // pack register bits into pin order
  assign reg_fields = {fmt_q[`SOF_B_BIT_WISE],
                       fmt_q[`SOF_B_LSB_FIRST],
                       fmt_q[`SOF_B_COARSE],
                       fmt_q[`SOF_B_CAP_RISE],
                       fmt_q[`SOF_B_SER14],
                       fmt_q[`SOF_B_SDR_CLK],
                       fmt_q[`SOF_B_TWO_WIRE]};
  assign ovrd = fmt_q[`SOF_B_OVRD];

  // outputs lag their source by one edge
  // merge and gate dependent fields
  sof_resolve u_resolve (
    .pclk            (pclk),
    .presetn         (presetn),
    .reg_fields      (reg_fields),
    .pin_fields      (pin_stable),
    .ovrd            (ovrd),
    .fmt_two_wire    (fmt_two_wire),
    .fmt_sdr_clk     (fmt_sdr_clk),
    .fmt_ser14       (fmt_ser14),
    .fmt_cap_rise    (fmt_cap_rise),
    .fmt_coarse_gain (fmt_coarse_gain),
    .fmt_lsb_first   (fmt_lsb_first),
    .fmt_bit_wise    (fmt_bit_wise),
    .gain_ddb        (gain_ddb),
    .fsr_mv          (fsr_mv)
  );

  // status register image
  // read-only view so software can see which source is in charge
  sof_fields_t eff_fields;   // effective fields in pin order
  logic [31:0] stat_word;    // status read value
  logic [31:0] fmt_word;     // format read value
  logic [31:0] rd_mux;       // selected read value

  // effective format as seen by the output link
  assign eff_fields = {fmt_bit_wise,
                       fmt_lsb_first,
                       fmt_coarse_gain,
                       fmt_cap_rise,
                       fmt_ser14,
                       fmt_sdr_clk,
                       fmt_two_wire};

  // status: [6:0] effective, [14:8] filtered pins, [16] override
  // bits 7 and 15 stay zero as spacers
  assign stat_word = {15'h0, ovrd, 1'b0, pin_stable, 1'b0, eff_fields};
  assign fmt_word  = {21'h0, fmt_q};
  // unmapped words read as zero
  assign rd_mux    = hit_fmt  ? fmt_word :
                     hit_stat ? stat_word : 32'h0000_0000;

  // read data register
  // loading only in a read setup keeps the status image from rippling out
  // capture in setup so data is steady through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata <= rd_mux;
    end
  end

  // checks
  // all on pclk, muted while presetn is low
  // a write to the format register lands masked one edge later
  a_fmt_write_lands: assert property ( // RULE_07
    @(posedge pclk) disable iff (!presetn)
    wr_fmt |=> (fmt_q == ($past(pwdata[10:0]) & `SOF_FMT_WMASK))
  ) else $error("format register did not take the written value");

  // reserved positions never hold a one
  a_reserved_stay_zero: assert property ( // RULE_08
    @(posedge pclk) disable iff (!presetn)
    (fmt_q[9:8] == 2'b00) && (fmt_q[3] == 1'b0)
  ) else $error("reserved format bits are set");

  // override set: outputs follow the register one edge later
  a_override_reg_path: assert property ( // RULE_07
    @(posedge pclk) disable iff (!presetn)
    ovrd |=> (fmt_ser14 == $past(fmt_q[`SOF_B_SER14]))
         && (fmt_two_wire == $past(fmt_q[`SOF_B_TWO_WIRE]))
  ) else $error("register setting did not take precedence over pins");

  // override clear: outputs follow the filtered pins
  a_pins_govern: assert property ( // RULE_06
    @(posedge pclk) disable iff (!presetn)
    !ovrd |=> (fmt_ser14 == $past(pin_stable[2]))
          && (fmt_coarse_gain == $past(pin_stable[4]))
  ) else $error("pin setting not used while override clear");

  // sdr bit clock only exists with two lanes
  a_sdr_needs_two: assert property ( // RULE_01
    @(posedge pclk) disable iff (!presetn)
    fmt_sdr_clk |-> fmt_two_wire
  ) else $error("sdr bit clock reported in one-wire mode");

  // capture edge choice only while sdr is active
  a_edge_needs_sdr: assert property ( // RULE_02
    @(posedge pclk) disable iff (!presetn)
    fmt_cap_rise |-> fmt_sdr_clk
  ) else $error("capture edge set without sdr bit clock");

  // coarse gain ties gain figure and full-scale range together
  a_coarse_range: assert property ( // RULE_03
    @(posedge pclk) disable iff (!presetn)
    fmt_coarse_gain ? (gain_ddb == 6'h23 && fsr_mv == 11'h53c)
                    : (gain_ddb == 6'h00 && fsr_mv == 11'h7d0)
  ) else $error("gain and full-scale range disagree with coarse gain");

  // bit order follows the selected source one edge later
  a_order_follows: assert property ( // RULE_04
    @(posedge pclk) disable iff (!presetn)
    ##1 fmt_lsb_first == $past(ovrd ? fmt_q[`SOF_B_LSB_FIRST] : pin_stable[5])
  ) else $error("bit order does not follow selected source");

  // lane split choice only with two lanes
  a_split_needs_two: assert property ( // RULE_05
    @(posedge pclk) disable iff (!presetn)
    fmt_bit_wise |-> fmt_two_wire
  ) else $error("bit-wise split reported in one-wire mode");

  // read of the format register returns the stored image
  a_read_back: assert property ( // RULE_07
    @(posedge pclk) disable iff (!presetn)
    (acc_phase && !pwrite && hit_fmt && $past(setup_rd)) |-> (prdata == fmt_word)
  ) else $error("format register read returned wrong data");

  // unmapped access flags an error and returns zero
  a_unmapped_err: assert property ( // RULE_07
    @(posedge pclk) disable iff (!presetn)
    (setup_rd && !hit_any) |=> (acc_phase ? (pslverr && prdata == 32'h0) : 1'b1)
  ) else $error("unmapped read did not error with zero data");

  // read data stays put after the access that returned it
  a_rdata_holds: assert property ( // RULE_07
    @(posedge pclk) disable iff (!presetn)
    (acc_phase && !pwrite) |=> $stable(prdata)
  ) else $error("read data moved right after a read access");

  // without a format write the stored image holds
  a_fmt_hold: assert property ( // RULE_07
    @(posedge pclk) disable iff (!presetn)
    !wr_fmt |=> $stable(fmt_q)
  ) else $error("format register changed without a write");

  // error response only in the access phase
  a_err_access_only: assert property ( // RULE_07
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> acc_phase
  ) else $error("error response outside the access phase");

  // status register is mapped, so it never errors
  a_status_no_err: assert property ( // RULE_07
    @(posedge pclk) disable iff (!presetn)
    (acc_phase && hit_stat) |-> !pslverr
  ) else $error("status access answered with an error");

  // override set: bit clock mode follows the register
  a_sdr_follows: assert property ( // RULE_01
    @(posedge pclk) disable iff (!presetn)
    ovrd |=> fmt_sdr_clk == $past(fmt_q[`SOF_B_TWO_WIRE] & fmt_q[`SOF_B_SDR_CLK])
  ) else $error("bit clock mode does not follow the register");

  // override set: capture edge follows the register, sdr only
  a_cap_follows: assert property ( // RULE_02
    @(posedge pclk) disable iff (!presetn)
    ovrd |=> fmt_cap_rise == $past(fmt_q[`SOF_B_TWO_WIRE] & fmt_q[`SOF_B_SDR_CLK]
                                   & fmt_q[`SOF_B_CAP_RISE])
  ) else $error("capture edge does not follow the register");

  // override set: coarse gain follows the register
  a_gain_follows: assert property ( // RULE_03
    @(posedge pclk) disable iff (!presetn)
    ovrd |=> fmt_coarse_gain == $past(fmt_q[`SOF_B_COARSE])
  ) else $error("coarse gain does not follow the register");

  // override set: lane split follows the register, two lanes only
  a_split_follows: assert property ( // RULE_05
    @(posedge pclk) disable iff (!presetn)
    ovrd |=> fmt_bit_wise == $past(fmt_q[`SOF_B_TWO_WIRE] & fmt_q[`SOF_B_BIT_WISE])
  ) else $error("lane split does not follow the register");

  // override clear: lane and clock mode follow the pins
  a_pins_lanes: assert property ( // RULE_06
    @(posedge pclk) disable iff (!presetn)
    !ovrd |=> (fmt_two_wire == $past(pin_stable[0]))
          && (fmt_sdr_clk == $past(pin_stable[0] & pin_stable[1]))
  ) else $error("lane or clock mode does not follow the pins");

  // override clear: gated fields follow the pins
  a_pins_gated: assert property ( // RULE_06
    @(posedge pclk) disable iff (!presetn)
    !ovrd |=> (fmt_bit_wise == $past(pin_stable[0] & pin_stable[6]))
          && (fmt_cap_rise == $past(pin_stable[0] & pin_stable[1] & pin_stable[3]))
  ) else $error("gated fields do not follow the pins");

endmodule // sof_regs

// ==== core/sof_resolve.sv ====
// Purpose: picks register or pin settings and gates dependent fields
// Assumes: both field sets already in the pclk domain
// Notes:   all outputs registered, one cycle behind the inputs
`include "sof_cfg.svh"
module sof_resolve
  import sof_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // field sources
  input  wire sof_fields_t reg_fields,
  input  wire sof_fields_t pin_fields,
  input  wire logic        ovrd,
  // effective format
  output logic             fmt_two_wire,
  output logic             fmt_sdr_clk,
  output logic             fmt_ser14,
  output logic             fmt_cap_rise,
  output logic             fmt_coarse_gain,
  output logic             fmt_lsb_first,
  output logic             fmt_bit_wise,
  // analog gain settings
  output logic [5:0]       gain_ddb,
  output logic [10:0]      fsr_mv
);

  sof_fields_t src;     // selected source
  logic        two_w;   // selected lane mode
  logic        sdr;     // sdr only exists with two lanes
  logic        coarse;  // coarse gain request

  // register wins when override set, pins otherwise
  assign src    = ovrd ? reg_fields : pin_fields; // RULE_06 RULE_07
  assign two_w  = src[0];
  assign sdr    = two_w & src[1];                 // RULE_01
  assign coarse = src[4];

  // register effective fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_two_wire    <= 1'b0;
      fmt_sdr_clk     <= 1'b0;
      fmt_ser14       <= 1'b0;
      fmt_cap_rise    <= 1'b0;
      fmt_coarse_gain <= 1'b0;
      fmt_lsb_first   <= 1'b0;
      fmt_bit_wise    <= 1'b0;
      gain_ddb        <= `SOF_GAIN_NONE_DDB;
      fsr_mv          <= `SOF_FSR_NOM_MV;
    end else begin
      fmt_two_wire    <= two_w;                   // RULE_01
      fmt_sdr_clk     <= sdr;
      fmt_ser14       <= src[2];                  // RULE_01
      fmt_cap_rise    <= sdr & src[3];            // RULE_02
      fmt_coarse_gain <= coarse;                  // RULE_03
      fmt_lsb_first   <= src[5];                  // RULE_04
      fmt_bit_wise    <= two_w & src[6];          // RULE_05
      gain_ddb        <= coarse ? `SOF_GAIN_COARSE_DDB : `SOF_GAIN_NONE_DDB;
      fsr_mv          <= coarse ? `SOF_FSR_COARSE_MV : `SOF_FSR_NOM_MV;
    end
  end

endmodule // sof_resolve

// ==== core/sof_sync.sv ====
// Purpose: three-stage synchroniser with agreement filter for pins
// Assumes: inputs asynchronous to pclk
// Notes:   output moves only when stages two and three agree
module sof_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // asynchronous pins in, filtered level out
  input  wire logic [W-1:0] pin_async,
  output logic      [W-1:0] pin_stable
);

  logic [W-1:0] s1_q;   // first stage, read by s2 only
  logic [W-1:0] s2_q;   // second stage
  logic [W-1:0] s3_q;   // third stage
  logic [W-1:0] agree;  // per-bit agreement of stages two and three

  assign agree = ~(s2_q ^ s3_q);

  // shift chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // take a new level only once two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_stable <= '0;
    end else begin
      pin_stable <= (agree & s3_q) | (~agree & pin_stable);
    end
  end

endmodule // sof_sync

// ==== dv/sof_rx_model.sv ====
// Purpose: receiver model that derives lane width, capture edge and bit order from the chosen format
// Assumes: format inputs are settled effective settings of the block
// Notes:   behavioural, gives lane width and capture edge to the bench
module sof_rx_model (
  // clock
  input  wire logic pclk,
  // effective format from the block
  input  wire logic two_wire,
  input  wire logic sdr_clk,
  input  wire logic ser14,
  input  wire logic cap_rise,
  input  wire logic lsb_first,
  input  wire logic bit_wise,
  // receiver view
  output int        lane_bits,
  output logic      rise_edge,
  output logic      lsb_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // bits per lane per sample, split across one or two lanes
  always_comb lane_bits = (ser14 ? 14 : 12) / (two_wire ? 2 : 1);
  // capture edge choice only counts with sdr bit clock
  always_comb rise_edge = sdr_clk & cap_rise;
  // bit order of the shifted word
  always_comb lsb_seen = lsb_first;
endmodule // sof_rx_model

// ==== dv/tb_serial_output_format_config.sv ====
// Purpose: self-checking bench for the serial output format register bank
// Assumes: zero-wait apb slave, pins reach outputs within 7 cycles
// Notes:   model derives effective format from pins or register image
`include "sof_cfg.svh"
module tb_serial_output_format_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  pin_fmt;
  logic        tw, sdr, s14, cap, co, lsb, bw, er, rxr, rxl;
  logic [5:0]  gain_ddb;
  logic [10:0] fsr_mv;
  int          rxb, n_mismatch, n_tests, cyc, seed, v, pins;
  // design under test
  sof_regs sof_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pin_fmt(pin_fmt), .fmt_two_wire(tw), .fmt_sdr_clk(sdr),
    .fmt_ser14(s14), .fmt_cap_rise(cap), .fmt_coarse_gain(co), .fmt_lsb_first(lsb),
    .fmt_bit_wise(bw), .gain_ddb(gain_ddb), .fsr_mv(fsr_mv));
  // far-side receiver
  sof_rx_model sof_rx_model_i (.pclk(pclk), .two_wire(tw), .sdr_clk(sdr), .ser14(s14),
    .cap_rise(cap), .lsb_first(lsb), .bit_wise(bw), .lane_bits(rxb), .rise_edge(rxr),
    .lsb_seen(rxl));
  // clock, 20 ns period
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      n_mismatch = n_mismatch + 1;
      close_out();
    end
  end
  // xorshift source
  function automatic int rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // register image to fields in pin order
  function automatic int r2f(int r);
    return (r & 7) | (((r >> 4) & 15) << 3);
  endfunction
  // expected outputs from fields, dependent fields gated
  function automatic logic [23:0] model(int f);
    logic a, b, c, d, e, g, h;
    a = f[0];
    b = f[1] & a;
    c = f[2];
    d = f[3] & b;
    e = f[4];
    g = f[5];
    h = f[6] & a;
    return {a, b, c, d, e, g, h, e ? 6'h23 : 6'h00, e ? 11'h53c : 11'h7d0};
  endfunction
  // one compare
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask
  // compare all effective outputs and the receiver view
  task automatic chk_out(int f);
    logic [23:0] e;
    logic [23:0] g;
    e = model(f);
    g = {tw, sdr, s14, cap, co, lsb, bw, gain_ddb, fsr_mv};
    chk("fmt", {8'h00, e}, {8'h00, g});
    chk("rx", (e[21] ? 14 : 12) / (e[23] ? 2 : 1), rxb);
    chk("rx_edge", {31'h0, e[20]}, {31'h0, rxr});
    chk("rx_lsb", {31'h0, e[18]}, {31'h0, rxl});
  endtask
  // one apb transfer, held until pready at an edge
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // wait some cycles
  task automatic idle(int n);
    repeat (n) @(posedge pclk);
  endtask
  // verdict
  task automatic close_out();
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pin_fmt} = '0;
    {n_mismatch, n_tests, cyc} = '0;
    seed = 49260;
    presetn = 1'b0;
    idle(5);
    presetn <= 1'b1;
    apb(1'b0, 12'h034, 32'h0);
    chk("fmt_reset", 32'h0, rd);
    // pins govern while override is clear
    for (int i = 0; i < 10; i++) begin
      pins = rnd() & 32'h7f;
      pin_fmt <= pins[6:0];
      idle(7);
      chk_out(pins);
    end
    // register overrides pins, unused bits read zero
    for (int i = 0; i < 10; i++) begin
      v = (rnd() & 32'h4f7) | 32'h400;
      if (i == 0) v = v | 32'h0f7;
      apb(1'b1, 12'h034, v);
      apb(1'b0, 12'h034, 32'h0);
      chk("fmt_rd", v & 32'h4f7, rd);
      chk("err", 32'h0, {31'h0, er});
      chk_out(r2f(v));
      pins = rnd() & 32'h7f;
      pin_fmt <= pins[6:0];
      idle(7);
      chk_out(r2f(v));
      apb(1'b0, 12'h038, 32'h0);
      chk("stat", {15'h0, 1'b1, 1'b0, pins[6:0], 8'h0}, rd & 32'h1ff00);
    end
    // status write ignored, unmapped place refused
    apb(1'b1, 12'h038, 32'h0);
    apb(1'b0, 12'h034, 32'h0);
    chk("fmt_keep", v & 32'h4f7, rd);
    apb(1'b1, 12'h03c, 32'h7ff);
    chk("err_wr", 32'h1, {31'h0, er});
    apb(1'b0, 12'h03c, 32'h0);
    chk("err_rd", 32'h1, {31'h0, er});
    chk("rd_unm", 32'h0, rd);
    // override cleared, pins govern again
    apb(1'b1, 12'h034, 32'h0f7);
    idle(3);
    chk_out(pins);
    // reset in mid-run clears register
    @(posedge pclk);
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    apb(1'b0, 12'h034, 32'h0);
    chk("fmt_rst2", 32'h0, rd);
    idle(7);
    chk_out(pins);
    close_out();
  end
endmodule // tb_serial_output_format_config

// ==== include/sof_cfg.svh ====
// Purpose: constants for the serial output format register block
// Assumes: included by bare name from design files
// Notes:   offsets are word indexes, byte address is four times index
`ifndef SOF_CFG_SVH
`define SOF_CFG_SVH

// register word indexes
`define SOF_FMT_IDX        10'h00d
`define SOF_STAT_IDX       10'h00e

// field positions in the output format register
`define SOF_B_TWO_WIRE     0
`define SOF_B_SDR_CLK      1
`define SOF_B_SER14        2
`define SOF_B_CAP_RISE     4
`define SOF_B_COARSE       5
`define SOF_B_LSB_FIRST    6
`define SOF_B_BIT_WISE     7
`define SOF_B_OVRD         10

// reset value and writable bits (9, 8 and 3 stay zero)
`define SOF_FMT_RST        11'h000
`define SOF_FMT_WMASK      11'h4f7

// gain in tenths of a dB, full-scale range in mVpp
`define SOF_GAIN_NONE_DDB  6'h00
`define SOF_GAIN_COARSE_DDB 6'h23
`define SOF_FSR_NOM_MV     11'h7d0
`define SOF_FSR_COARSE_MV  11'h53c

// width of the configuration pin vector
`define SOF_PIN_W          7

`endif

// ==== include/sof_pkg.sv ====
// Purpose: shared types for the serial output format register block
// Assumes: nothing
// Notes:   constants live in sof_cfg.svh
package sof_pkg;

  // stored register image, 11 bits
  typedef logic [10:0] sof_fmt_t;
  // format fields in pin order: two_wire, sdr, ser14, cap_rise, coarse, lsb, bit_wise
  typedef logic [6:0]  sof_fields_t;

endpackage : sof_pkg
